//--- hdl/zrc_combiner.sv
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module zrc_combiner
    import zrc_pkg::*;
#(
    parameter int LINES = zrc_pkg::NUM_LINES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [zrc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic trigger,
    input wire zrc_pkg::zrc_win_s win_in,
    input wire logic [2:0] task_select_inputs,
    input wire logic fieldbus_sel_valid,
    input wire logic [zrc_pkg::TASK_W-1:0] fieldbus_task,
    output logic [zrc_pkg::TASK_W-1:0] active_task,
    output logic [zrc_pkg::NUM_LINES-1:0] switching_line_1_to_4,
    output logic [7:0] fieldbus_status_byte
);
    import zrc_pkg::*;

    typedef enum logic [1:0] {
        ZRC_IDLE = 2'b00,
        ZRC_SAMPLE = 2'b01,
        ZRC_EVAL = 2'b11
    } zrc_state_e;

    zrc_state_e state_r;
    zrc_win_s win_r;
    zrc_line_s line_r [NUM_LINES];
    logic [MARK_W-1:0] mark_r [NUM_LINES];
    logic ext_sel_r, single_r, req_pend_r, shot_done_r;
    logic [TASK_W-1:0] cfg_task_r, fb_task_r, task_r;
    logic fb_seen_r;
    logic [NUM_LINES-1:0] line_out_r, raw_prev_r;
    logic [DEPTH_W-1:0] cnt_r [NUM_LINES];
    logic ack_r;
    logic [3:0] nv_idx_r;
    logic nv_we;
    logic [31:0] nv_rdata;
    logic [NUM_LINES-1:0] raw_nxt;
    logic [SUM_W-1:0] sum_nxt [NUM_LINES];
    logic [NUM_COLS-1:0] col_res [NUM_LINES];
    logic [1:0] sel_line;
    logic wr, rd;

    // A write lands on the edge that sees waitrequest low, never earlier
    assign wr = avs_write && ack_r;
    assign rd = avs_read && !ack_r;
    // One wait cycle: every access answers on the second edge
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign sel_line = avs_writedata[SEL_LINE_LSB +: 2];

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read || avs_write) && !ack_r;
    end

    // Task selection
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fb_task_r <= 4'h0;
            fb_seen_r <= 1'b0;
        end
        else if (fieldbus_sel_valid)
        begin
            fb_task_r <= fieldbus_task;
            fb_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            task_r <= 4'h0;
        else if (ext_sel_r)
            // Last fieldbus choice wins over pins once the fieldbus has spoken
            task_r <= fb_seen_r ? fb_task_r : {1'b0, task_select_inputs};
        else
            task_r <= cfg_task_r;
    end
    assign active_task = task_r;

    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_sel_r <= 1'b0;
            single_r <= 1'b0;
            cfg_task_r <= 4'h0;
            for (int i = 0; i < NUM_LINES; i++)
            begin
                line_r[i] <= '{DEPTH_DEF, 1'b1, 1'b0, 1'b0, HITS_ON_DEF, HITS_OFF_DEF};
                mark_r[i] <= '0;
            end
        end
        else if (wr && avs_address == REG_CMD && avs_writedata[CMD_FACTORY])
        begin
            ext_sel_r <= 1'b0;
            single_r <= 1'b0;
            cfg_task_r <= 4'h0;
            for (int i = 0; i < NUM_LINES; i++)
            begin
                line_r[i] <= '{DEPTH_DEF, 1'b1, 1'b0, 1'b0, HITS_ON_DEF, HITS_OFF_DEF};
                mark_r[i] <= '0;
            end
        end
        else if (wr && avs_address == REG_CTRL)
        begin
            ext_sel_r <= avs_writedata[CTRL_EXT_SEL];
            single_r <= avs_writedata[CTRL_SINGLE];
            if (!ext_sel_r)
                cfg_task_r <= avs_writedata[CTRL_TASK_LSB +: TASK_W];
        end
        else if (wr && avs_address == REG_LINE_CFG)
        begin
            line_r[sel_line].sum_mode <= avs_writedata[LC_SUM];
            line_r[sel_line].invert <= avs_writedata[LC_INV];
            line_r[sel_line].active <= avs_writedata[LC_ACT];
            // Depth zero is meaningless and clamps to one
            line_r[sel_line].depth <= (avs_writedata[LC_DEPTH_LSB +: DEPTH_W] == '0) ?
                DEPTH_DEF : avs_writedata[LC_DEPTH_LSB +: DEPTH_W];
        end
        else if (wr && avs_address == REG_THRESH)
        begin
            line_r[sel_line].hits_on <= avs_writedata[0 +: HIT_W];
            line_r[sel_line].hits_off <= avs_writedata[THR_OFF_LSB +: HIT_W];
        end
        else if (wr && avs_address == REG_MARK)
        begin
            mark_r[sel_line][avs_writedata[SEL_COL_LSB +: 2] * (2 * NUM_WIN) +: 2 * NUM_WIN]
                <= (2 * NUM_WIN)'(avs_writedata[23:0]);
        end
    end

    // Store and read-back share the parameter memory, one word per task
    assign nv_we = wr && avs_address == REG_CMD && avs_writedata[CMD_STORE];
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            nv_idx_r <= 4'h0;
        else if (wr && avs_address == REG_CMD && avs_writedata[CMD_RDBACK])
            nv_idx_r <= avs_writedata[CTRL_TASK_LSB +: TASK_W];
        else if (nv_we)
            nv_idx_r <= task_r;
    end

    zrc_nv_store #(.DEPTH(NUM_TASKS), .WIDTH(32), .AW(TASK_W)) u_nv (
        .core_clk(core_clk),
        .we(nv_we),
        .addr(nv_we ? task_r : nv_idx_r),
        .wdata({line_r[0].depth, line_r[1].depth, line_r[2].depth, line_r[3].depth}),
        .rdata(nv_rdata)
    );

    // Trigger sequencing
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_pend_r <= 1'b0;
            shot_done_r <= 1'b0;
        end
        else
        begin
            // A request landing with the closing evaluation stays armed
            if (wr && avs_address == REG_CMD && avs_writedata[CMD_REQ])
                req_pend_r <= 1'b1;
            else if (state_r == ZRC_EVAL && single_r)
                req_pend_r <= 1'b0;
            // Done flag: the evaluation wins over a clearing request
            if (state_r == ZRC_EVAL && single_r)
                shot_done_r <= 1'b1;
            else if (wr && avs_address == REG_CMD && avs_writedata[CMD_REQ])
                shot_done_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ZRC_IDLE;
        else
        begin
            unique case (state_r)
                ZRC_IDLE:
                    if (trigger && (!single_r || req_pend_r))
                        state_r <= ZRC_SAMPLE;
                ZRC_SAMPLE:
                    state_r <= ZRC_EVAL;
                ZRC_EVAL:
                    state_r <= ZRC_IDLE;
                default:
                    state_r <= ZRC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            win_r <= '0;
        else if (state_r == ZRC_IDLE && trigger)
            win_r <= win_in;
    end

    // Combinational evaluation
    always_comb
    begin
        for (int l = 0; l < NUM_LINES; l++)
        begin
            sum_nxt[l] = '0;
            for (int c = 0; c < NUM_COLS; c++)
            begin
                col_res[l][c] = 1'b1;
                for (int w = 0; w < NUM_WIN; w++)
                begin
                    if (mark_r[l][(c*NUM_WIN+w)*2 +: 2] == ZRC_MARK_PLUS)
                        col_res[l][c] = col_res[l][c] & win_r.present[w];
                    else if (mark_r[l][(c*NUM_WIN+w)*2 +: 2] == ZRC_MARK_MINUS)
                        col_res[l][c] = col_res[l][c] & ~win_r.present[w];
                end
            end
            for (int w = 0; w < NUM_WIN; w++)
            begin
                if (mark_r[l][w*2 +: 2] == ZRC_MARK_PLUS)
                    sum_nxt[l] = sum_nxt[l] + SUM_W'(win_r.hits[w*HIT_W +: HIT_W]);
            end
            if (line_r[l].sum_mode)
            begin
                if (sum_nxt[l] >= SUM_W'(line_r[l].hits_on))
                    raw_nxt[l] = 1'b1;
                else if (sum_nxt[l] <= SUM_W'(line_r[l].hits_off))
                    raw_nxt[l] = 1'b0;
                else
                    raw_nxt[l] = line_out_r[l];
            end
            else
                raw_nxt[l] = (|col_res[l]) ^ line_r[l].invert;
        end
    end

    // Depth filter
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_out_r <= '0;
            raw_prev_r <= '0;
            for (int l = 0; l < NUM_LINES; l++)
                cnt_r[l] <= '0;
        end
        else if (state_r == ZRC_EVAL)
        begin
            raw_prev_r <= raw_nxt;
            for (int l = 0; l < NUM_LINES; l++)
            begin
                if (!line_r[l].active)
                begin
                    line_out_r[l] <= 1'b0;
                    cnt_r[l] <= '0;
                end
                else if (raw_nxt[l] == line_out_r[l])
                    cnt_r[l] <= '0;
                else if (raw_nxt[l] != raw_prev_r[l] && cnt_r[l] != '0)
                    cnt_r[l] <= DEPTH_W'(1) == line_r[l].depth ? '0 : DEPTH_W'(1);
                else if (cnt_r[l] + DEPTH_W'(1) >= line_r[l].depth)
                begin
                    line_out_r[l] <= raw_nxt[l];
                    cnt_r[l] <= '0;
                end
                else
                    cnt_r[l] <= cnt_r[l] + DEPTH_W'(1);
            end
        end
    end
    assign switching_line_1_to_4 = line_out_r;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            fieldbus_status_byte <= 8'h00;
        else
            fieldbus_status_byte <= {task_r, line_out_r};
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0;
        else if (rd)
        begin
            unique case (avs_address)
                REG_CTRL: avs_readdata <= {24'h0, cfg_task_r, 2'h0, single_r, ext_sel_r};
                REG_STATUS: avs_readdata <= {16'h0, 2'h0, shot_done_r, req_pend_r,
                    task_r, 4'h0, line_out_r};
                REG_NV_RD: avs_readdata <= nv_rdata;
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    a_single_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (single_r && !req_pend_r) |-> ##1 (state_r != ZRC_SAMPLE))
        else $error("second analysis without request");
    a_line_only_eval: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r != ZRC_EVAL) |=> $stable(line_out_r))
        else $error("line changed outside evaluation");
    a_sample_trig: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == ZRC_SAMPLE) |-> $past(trigger))
        else $error("sampled without trigger");
    a_wait_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer late");
    a_ext_task: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ext_sel_r && !fb_seen_r) |=> active_task == {1'b0, $past(task_select_inputs)})
        else $error("pin task not taken");
    a_cfg_task: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ext_sel_r |=> active_task == $past(cfg_task_r))
        else $error("configured task not taken");
    a_inactive_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == ZRC_EVAL && !line_r[0].active) |=> !switching_line_1_to_4[0])
        else $error("inactive line high");
    a_sum_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == ZRC_EVAL && line_r[1].sum_mode && line_r[1].active
            && line_r[1].depth == DEPTH_DEF && sum_nxt[1] >= SUM_W'(line_r[1].hits_on))
        |=> switching_line_1_to_4[1])
        else $error("sum threshold ignored");
endmodule : zrc_combiner
`default_nettype wire

//--- hdl/zrc_pkg.sv
`default_nettype none
package zrc_pkg;
    localparam int NUM_LINES = 4;
    localparam int NUM_COLS = 4;
    localparam int NUM_WIN = 16;
    localparam int NUM_TASKS = 16;
    localparam int HIT_W = 9;
    localparam int SUM_W = 13;
    localparam int DEPTH_W = 8;
    localparam int TASK_W = 4;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h08;
    localparam logic [ADDR_W-1:0] REG_LINE_CFG = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_THRESH = 8'h10;
    localparam logic [ADDR_W-1:0] REG_MARK = 8'h14;
    localparam logic [ADDR_W-1:0] REG_NV_RD = 8'h18;

    // CTRL fields
    localparam int CTRL_EXT_SEL = 0;
    localparam int CTRL_SINGLE = 1;
    localparam int CTRL_TASK_LSB = 4;

    // CMD fields
    localparam int CMD_STORE = 0;
    localparam int CMD_FACTORY = 1;
    localparam int CMD_REQ = 2;
    localparam int CMD_RDBACK = 3;

    // Per-line config word layout
    localparam int LC_SUM = 0;
    localparam int LC_INV = 1;
    localparam int LC_ACT = 2;
    localparam int LC_DEPTH_LSB = 8;

    // Line select field in REG_LINE_CFG/THRESH/MARK: bits 29:28, column 27:26
    localparam int SEL_LINE_LSB = 28;
    localparam int SEL_COL_LSB = 26;
    localparam int THR_OFF_LSB = 12;

    localparam logic [DEPTH_W-1:0] DEPTH_DEF = 8'h01;
    localparam logic [DEPTH_W-1:0] DEPTH_MAX = 8'hff;
    localparam logic [HIT_W-1:0] HITS_ON_DEF = 9'h00a;
    localparam logic [HIT_W-1:0] HITS_OFF_DEF = 9'h000;

    // Mark codes per window
    typedef enum logic [1:0] {
        ZRC_MARK_NONE = 2'h0,
        ZRC_MARK_PLUS = 2'h1,
        ZRC_MARK_MINUS = 2'h2
    } zrc_mark_e;

    typedef struct packed {
        logic [NUM_WIN-1:0] present;
        logic [NUM_WIN*HIT_W-1:0] hits;
    } zrc_win_s;

    typedef struct packed {
        logic [DEPTH_W-1:0] depth;
        logic active;
        logic invert;
        logic sum_mode;
        logic [HIT_W-1:0] hits_on;
        logic [HIT_W-1:0] hits_off;
    } zrc_line_s;

    localparam int LINE_W = DEPTH_W + 3 + 2 * HIT_W;
    localparam int MARK_W = NUM_COLS * NUM_WIN * 2;
endpackage : zrc_pkg
`default_nettype wire

//--- hdl/zrc_nv_store.sv
`timescale 1ns/1ps
`default_nettype none
// Parameter memory of all inspection tasks; read data come from a register
module zrc_nv_store #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32,
    parameter int AW = 4
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : zrc_nv_store
`default_nettype wire

//--- bench/zrc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Process control: drives the task select pins and the fieldbus selection
module zrc_ctl_model (
    input wire logic core_clk,
    output logic [2:0] task_select_inputs,
    output logic fieldbus_sel_valid,
    output logic [zrc_pkg::TASK_W-1:0] fieldbus_task
);
    import zrc_pkg::*;

    initial
    begin
        task_select_inputs = 3'h0;
        fieldbus_sel_valid = 1'b0;
        fieldbus_task = 4'h0;
    end

    // Pins are static levels; dly models a slow control
    task automatic set_pins(input logic [2:0] v, input int dly);
        repeat (dly) @(posedge core_clk);
        task_select_inputs <= v;
        @(posedge core_clk);
    endtask : set_pins

    // Task code is only meaningful with the strobe, so scramble it afterwards
    task automatic fb_select(input logic [TASK_W-1:0] t);
        fieldbus_task <= t;
        fieldbus_sel_valid <= 1'b1;
        @(posedge core_clk);
        fieldbus_sel_valid <= 1'b0;
        fieldbus_task <= ~t;
        @(posedge core_clk);
    endtask : fb_select
endmodule : zrc_ctl_model
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import zrc_pkg::*;
    logic core_clk;
    logic rst_n;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic trigger;
    zrc_win_s win_in;
    logic [2:0] task_select_inputs;
    logic fieldbus_sel_valid;
    logic [TASK_W-1:0] fieldbus_task;
    logic [TASK_W-1:0] active_task;
    logic [NUM_LINES-1:0] switching_line_1_to_4;
    logic [7:0] fieldbus_status_byte;
    int seed = 29792;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [31:0] q;
    logic [23:0] mk [16];
    logic [3:0] inv_v;
    logic [143:0] h;
    logic [15:0] p;

    zrc_combiner u_zrc_combiner (.core_clk(core_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trigger(trigger), .win_in(win_in),
        .task_select_inputs(task_select_inputs), .fieldbus_sel_valid(fieldbus_sel_valid),
        .fieldbus_task(fieldbus_task), .active_task(active_task),
        .switching_line_1_to_4(switching_line_1_to_4),
        .fieldbus_status_byte(fieldbus_status_byte));

    zrc_ctl_model u_zrc_ctl_model (.core_clk(core_clk),
        .task_select_inputs(task_select_inputs), .fieldbus_sel_valid(fieldbus_sel_valid),
        .fieldbus_task(fieldbus_task));

    always #50 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_out(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_out

    // Entered right after a rising edge; data taken at the edge that sees waitrequest low
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic cfg(input logic [1:0] l, input logic [7:0] dp, input logic i, input logic s);
        bus(1'b0, REG_LINE_CFG, {2'h0, l, 12'h0, dp, 5'h0, 1'b1, i, s});
    endtask : cfg

    task automatic put_mark(input int k);
        bus(1'b0, REG_MARK, {2'h0, 2'(k / 4), 2'(k % 4), 2'h0, mk[k]});
    endtask : put_mark

    // Lines settle two edges after the trigger edge; four leaves margin
    task automatic trig(input logic [15:0] pr, input logic [143:0] hv);
        win_in <= '{present: pr, hits: hv};
        trigger <= 1'b1;
        @(posedge core_clk);
        trigger <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : trig

    task automatic wait_task(input logic [3:0] e);
        int n;
        n = 0;
        while (active_task !== e && n < 8)
        begin
            @(posedge core_clk);
            n++;
        end
        chk_out("active_task", {4'h0, e}, {4'h0, active_task});
    endtask : wait_task

    function automatic logic [3:0] exp_lines(input logic [15:0] pr);
        logic [3:0] r;
        logic c;
        r = 4'h0;
        for (int l = 0; l < 4; l++)
            for (int k = 0; k < 4; k++)
            begin
                c = 1'b1;
                for (int w = 0; w < 12; w++)
                    if ((mk[l*4+k][2*w+:2] == 2'h1 && !pr[w]) || (mk[l*4+k][2*w+:2] == 2'h2 && pr[w]))
                        c = 1'b0;
                r[l] = r[l] | c;
            end
        return r ^ inv_v;
    endfunction : exp_lines

    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        trigger = 1'b0;
        win_in = '0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk_out("lines", 8'h00, {4'h0, switching_line_1_to_4});
        bus(1'b1, 8'h40, 32'h0);
        chk_reg("unmapped", 32'h0, q);
        bus(1'b0, 8'h44, 32'hffffffff);
        bus(1'b1, REG_CTRL, 32'h0);
        chk_reg("ctrl", 32'h0, q);
        trig(16'h0, 144'h0);
        chk_out("lines", 8'h0f, {4'h0, switching_line_1_to_4});
        for (int it = 0; it < 12; it++)
        begin
            for (int k = 0; k < 16; k++)
            begin
                mk[k] = 24'h0;
                for (int w = 0; w < 3; w++)
                    mk[k][2*w+:2] = 2'({$random(seed)} % 3);
                put_mark(k);
            end
            for (int l = 0; l < 4; l++)
            begin
                inv_v[l] = 1'($random(seed));
                cfg(2'(l), 8'h01, inv_v[l], 1'b0);
            end
            p = 16'($random(seed));
            trig(p, 144'h0);
            chk_out("lines", {4'h0, exp_lines(p)}, {4'h0, switching_line_1_to_4});
        end
        inv_v = 4'h0;
        for (int k = 0; k < 16; k++)
        begin
            mk[k] = 24'h1;
            put_mark(k);
        end
        for (int l = 0; l < 4; l++)
            cfg(2'(l), (l == 0) ? 8'h03 : (l == 1) ? 8'h00 : 8'h01, 1'b0, 1'b0);
        for (int i = 0; i < 9; i++)
        begin
            p = {7'h0, 9'b111011000 >> i};
            trig(p, 144'h0);
            if (i >= 2)
                chk_out("lines", {4'h0, {3{p[0]}}, 1'((9'b100000000 >> i) & 1)},
                    {4'h0, switching_line_1_to_4});
        end
        for (int l = 0; l < 4; l++)
            cfg(2'(l), 8'h01, 1'b0, (l == 1));
        mk[4] = 24'h000095;
        mk[5] = 24'h000100;
        put_mark(4);
        put_mark(5);
        bus(1'b0, REG_THRESH, {2'h0, 2'h1, 7'h0, 9'h00a, 3'h0, 9'h014});
        for (int i = 0; i < 6; i++)
        begin
            int s;
            int a;
            int b;
            s = (i == 0) ? 25 : (i == 2) ? 10 : (i == 4) ? 20 : (i == 5) ? 11 : 15;
            a = {$random(seed)} % 6;
            b = {$random(seed)} % 4;
            h = 144'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
            h[27+:18] = 18'h3ffff;
            h[0+:27] = {9'(b), 9'(a), 9'(s - a - b)};
            trig(16'($random(seed)), h);
            chk_out("sum line", {7'h0, 1'((6'b110011 >> i) & 1)},
                {7'h0, switching_line_1_to_4[1]});
        end
        trig(16'h0, 144'h0);
        chk_out("lines", 8'h00, {4'h0, switching_line_1_to_4});
        bus(1'b0, REG_CTRL, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            if ((4'b1010 >> i) & 1)
                bus(1'b0, REG_CMD, 32'h4);
            p = {15'h0, 1'((4'b0011 >> i) & 1)};
            trig(p, {135'h0, p[0] ? 9'h01e : 9'h000});
            chk_out("shot lines", (i == 1 || i == 2) ? 8'h0f : 8'h00,
                {4'h0, switching_line_1_to_4});
        end
        bus(1'b0, REG_CTRL, 32'h0);
        for (int l = 0; l < 4; l++)
            cfg(2'(l), 8'(l + 3), 1'b0, 1'b0);
        bus(1'b0, REG_CMD, 32'h1);
        bus(1'b0, REG_CMD, 32'h8);
        bus(1'b1, REG_NV_RD, 32'h0);
        chk_reg("stored depths", 32'h03040506, q);
        bus(1'b0, REG_CMD, 32'h2);
        trig(16'hffff, 144'h0);
        chk_out("lines", 8'h0f, {4'h0, switching_line_1_to_4});
        bus(1'b0, REG_LINE_CFG, 32'h00000100);
        trig(16'hffff, 144'h0);
        chk_out("inactive line", 8'h0e, {4'h0, switching_line_1_to_4});
        bus(1'b0, REG_CTRL, 32'h50);
        wait_task(4'h5);
        bus(1'b0, REG_CTRL, 32'h91);
        for (int v = 0; v < 8; v++)
        begin
            u_zrc_ctl_model.set_pins(3'(v), v % 3);
            wait_task(4'(v));
        end
        bus(1'b0, REG_CTRL, 32'hf1);
        wait_task(4'h7);
        bus(1'b1, REG_CTRL, 32'h0);
        chk_reg("ctrl task", 32'h00000091, q);
        u_zrc_ctl_model.fb_select(4'hc);
        wait_task(4'hc);
        u_zrc_ctl_model.fb_select(4'hf);
        wait_task(4'hf);
        u_zrc_ctl_model.set_pins(3'h2, 0);
        repeat (2) @(posedge core_clk);
        wait_task(4'hf);
        chk_out("status byte", 8'hfe, fieldbus_status_byte);
        bus(1'b1, REG_STATUS, 32'h0);
        chk_reg("status", 32'h00000f0e, q & 32'h00000f0f);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
